//--- core/emmi_regs.vh
`ifndef EMMI_REGS_VH
`define EMMI_REGS_VH
`define EMMI_ADDR_CONFIG     2'h0
`define EMMI_ADDR_PAGE       2'h1
`define EMMI_ADDR_STATUS     2'h2
`define EMMI_ADDR_STROBE     2'h3
`define EMMI_CONFIG_RESET    8'h03
`define EMMI_CONFIG_MASK     8'h0f
`define EMMI_PAGE_RESET      8'h00
`define EMMI_STROBE_RESET    8'h00
`define EMMI_MODE_HI         3
`define EMMI_MODE_LO         2
`define EMMI_WIDTH_HI        1
`define EMMI_WIDTH_LO        0
`define EMMI_MODE_INTERNAL   2'h0
`define EMMI_MODE_SPLIT      2'h1
`define EMMI_MODE_BANK       2'h2
`define EMMI_MODE_EXTERNAL   2'h3
`define EMMI_ONCHIP_AW       11
`define EMMI_FIXED_CYCLES    4'h4
`endif

//--- core/emmi_ram.v
`timescale 1ns/100ps
`default_nettype none
// On-chip 2 kB data RAM with registered read data
module emmi_ram (
    // Clock
    input  wire        clk,
    input  wire        ce,
    // Port
    input  wire        wr,
    input  wire [10:0] addr,
    input  wire [7:0]  wdata,
    output reg  [7:0]  rdata
);
    reg [7:0] mem [0:2047];

    always @(posedge clk) begin
        if (ce) begin
            if (wr) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule
`default_nettype wire

//--- core/emmi_sync.v
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for the external data pins
module emmi_sync (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    // Data
    input  wire [7:0] din,
    output reg  [7:0] dout
);
    reg [7:0] meta;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 8'h00;
            dout <= 8'h00;
        end else if (ce) begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule
`default_nettype wire

//--- core/emmi_top.v
`timescale 1ns/100ps
`default_nettype none
`include "emmi_regs.vh"
// External data-memory interface: on-chip/off-chip steering and multiplexed port
module emmi_top (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    // Avalon-MM register slave
    input  wire [1:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // Core external-data move request
    input  wire        xreq,
    input  wire        xreq_write,
    input  wire        xreq_short,
    input  wire [15:0] xreq_addr,
    input  wire [7:0]  xreq_wdata,
    output reg         xdone,
    output reg  [7:0]  xrdata,
    // Multiplexed external port
    input  wire [7:0]  ad_in,
    output reg  [7:0]  ad_out,
    output reg         ad_oe,
    output reg  [7:0]  addr_hi_out,
    output reg         addr_hi_oe,
    output reg         latch_enable,
    output reg         rd_n,
    output reg         wr_n
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_RAM   = 3'h1;
    localparam ST_RAMRD = 3'h2;
    localparam ST_ALEH  = 3'h3;
    localparam ST_ALEL  = 3'h4;
    localparam ST_STRB  = 3'h5;
    localparam ST_TAIL  = 3'h6;

    reg  [7:0]  ext_mem_config;
    reg  [7:0]  xdata_page_reg;
    reg  [7:0]  strobe_extra;
    reg  [2:0]  state;
    reg  [3:0]  count;
    reg  [15:0] eff_addr;
    reg         is_write;
    reg         is_short;
    reg         ram_wr;
    reg  [7:0]  ram_wdata;
    reg  [10:0] ram_addr;
    reg         go_offchip;
    reg  [15:0] next_addr;
    wire [7:0]  ram_rdata;
    wire [7:0]  ad_sync;

    wire [1:0] map_mode_sel      = ext_mem_config[`EMMI_MODE_HI:`EMMI_MODE_LO];
    wire       map_mode_high_bit = ext_mem_config[`EMMI_MODE_HI];
    wire [1:0] latch_pulse_width = ext_mem_config[`EMMI_WIDTH_HI:`EMMI_WIDTH_LO];
    // Width code only counts with mode high bit clear, else shortest pulse
    wire [3:0] ale_cycles = map_mode_high_bit ? 4'h1 : {2'b00, latch_pulse_width} + 4'h1;

    emmi_ram u_ram (
        .clk   (clk),
        .ce    (ce),
        .wr    (ram_wr),
        .addr  (ram_addr),
        .wdata (ram_wdata),
        .rdata (ram_rdata)
    );

    emmi_sync u_sync (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .din  (ad_in),
        .dout (ad_sync)
    );

    // Address steering for a new move
    always @* begin
        next_addr = xreq_short ? {xdata_page_reg, xreq_addr[7:0]} : xreq_addr;
        case (map_mode_sel)
            `EMMI_MODE_INTERNAL: go_offchip = 1'b0;
            `EMMI_MODE_SPLIT:    go_offchip = (next_addr[15:11] != 5'h00);
            `EMMI_MODE_BANK:     go_offchip = (next_addr[15:11] != 5'h00);
            `EMMI_MODE_EXTERNAL: go_offchip = 1'b1;
            default:             go_offchip = 1'b1;
        endcase
    end

    // Register slave: one wait cycle on every access
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_mem_config  <= `EMMI_CONFIG_RESET;
            xdata_page_reg  <= `EMMI_PAGE_RESET;
            strobe_extra    <= `EMMI_STROBE_RESET;
            avs_readdata    <= 32'h00000000;
            avs_waitrequest <= 1'b1;
        end else if (ce) begin
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                if (avs_write) begin
                    case (avs_address)
                        `EMMI_ADDR_CONFIG: ext_mem_config <= avs_writedata[7:0] & `EMMI_CONFIG_MASK;
                        `EMMI_ADDR_PAGE:   xdata_page_reg <= avs_writedata[7:0];
                        `EMMI_ADDR_STROBE: strobe_extra   <= {4'h0, avs_writedata[3:0]};
                        default: ;
                    endcase
                end
                case (avs_address)
                    `EMMI_ADDR_CONFIG: avs_readdata <= {24'h000000, ext_mem_config};
                    `EMMI_ADDR_PAGE:   avs_readdata <= {24'h000000, xdata_page_reg};
                    `EMMI_ADDR_STATUS: avs_readdata <= {29'h00000000, state};
                    `EMMI_ADDR_STROBE: avs_readdata <= {24'h000000, strobe_extra};
                    default:           avs_readdata <= 32'h00000000;
                endcase
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // Access sequencer
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state        <= ST_IDLE;
            count        <= 4'h0;
            eff_addr     <= 16'h0000;
            is_write     <= 1'b0;
            is_short     <= 1'b0;
            ram_wr       <= 1'b0;
            ram_wdata    <= 8'h00;
            ram_addr     <= 11'h000;
            xdone        <= 1'b0;
            xrdata       <= 8'h00;
            ad_out       <= 8'h00;
            ad_oe        <= 1'b0;
            addr_hi_out  <= 8'h00;
            addr_hi_oe   <= 1'b0;
            latch_enable <= 1'b0;
            rd_n         <= 1'b1;
            wr_n         <= 1'b1;
        end else if (ce) begin
            xdone  <= 1'b0;
            ram_wr <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // The done cycle blocks a retake while the requester drops xreq
                    if (xreq && !xdone) begin
                        eff_addr  <= next_addr;
                        is_write  <= xreq_write;
                        is_short  <= xreq_short;
                        ram_wdata <= xreq_wdata;
                        ad_out    <= xreq_wdata;
                        if (go_offchip) begin
                            // Phase one: low address on shared lines, latch open
                            state        <= ST_ALEH;
                            count        <= ale_cycles;
                            ad_out       <= next_addr[7:0];
                            ad_oe        <= 1'b1;
                            latch_enable <= 1'b1;
                            addr_hi_out  <= next_addr[15:8];
                            // Short moves leave port latches alone unless bank mode
                            addr_hi_oe   <= !xreq_short || (map_mode_sel == `EMMI_MODE_BANK);
                        end else begin
                            state    <= ST_RAM;
                            ram_addr <= next_addr[10:0];
                            ram_wr   <= xreq_write;
                        end
                    end
                end
                ST_RAM: begin
                    state <= ST_RAMRD;
                end
                ST_RAMRD: begin
                    xrdata <= ram_rdata;
                    xdone  <= 1'b1;
                    state  <= ST_IDLE;
                end
                ST_ALEH: begin
                    if (count == 4'h1) begin
                        latch_enable <= 1'b0;
                        ad_oe        <= 1'b0;
                        state        <= ST_ALEL;
                        count        <= ale_cycles;
                    end else begin
                        count <= count - 4'h1;
                    end
                end
                ST_ALEL: begin
                    if (count == 4'h1) begin
                        // Full low period done before strobe
                        state <= ST_STRB;
                        count <= strobe_extra[3:0] + 4'h1;
                        ad_out <= ram_wdata;
                        ad_oe  <= is_write;
                        wr_n   <= !is_write;
                        rd_n   <= is_write;
                    end else begin
                        count <= count - 4'h1;
                    end
                end
                ST_STRB: begin
                    if (count == 4'h1) begin
                        rd_n   <= 1'b1;
                        wr_n   <= 1'b1;
                        state  <= ST_TAIL;
                        // Remaining fixed overhead completes the move
                        count  <= `EMMI_FIXED_CYCLES - 4'h1;
                    end else begin
                        count <= count - 4'h1;
                    end
                end
                ST_TAIL: begin
                    ad_oe <= 1'b0;
                    // Pin value from the last strobe cycle leaves the synchroniser now
                    if (count == 4'h2 && !is_write) begin
                        xrdata <= ad_sync;
                    end
                    if (count == 4'h1) begin
                        addr_hi_oe <= 1'b0;
                        xdone      <= 1'b1;
                        state      <= ST_IDLE;
                    end else begin
                        count <= count - 4'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- dv/emmi_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module emmi_top_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Register bus
    input wire logic [1:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    // External port
    input wire logic        ad_oe,
    input wire logic        addr_hi_oe,
    input wire logic        latch_enable,
    input wire logic        rd_n,
    input wire logic        wr_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0] cfg;
    logic [7:0] hc;
    logic [7:0] lc;
    // Width is one cycle whenever the mode high bit is set
    wire  [7:0] w = cfg[3] ? 8'h01 : {6'h00, cfg[1:0]} + 8'h01;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg <= 4'h3;
            hc  <= 8'h00;
            lc  <= 8'h00;
        end else begin
            if (avs_write && !avs_waitrequest && avs_address == 2'h0) cfg <= avs_writedata[3:0];
            hc <= latch_enable ? hc + 8'h01 : 8'h00;
            lc <= latch_enable ? 8'h00 : lc + 8'h01;
        end
    end
    property p_le_hi; $fell(latch_enable) |-> hc == w; endproperty
    a_le_hi: assert property (p_le_hi) else $error("latch high width wrong");
    property p_strobe; $fell(rd_n) || $fell(wr_n) |-> lc == w && !latch_enable; endproperty
    a_strobe: assert property (p_strobe) else $error("strobe before latch low period");
    property p_addr; latch_enable |-> ad_oe; endproperty
    a_addr: assert property (p_addr) else $error("address not driven in latch phase");
    property p_rd; !rd_n |-> !ad_oe && !latch_enable; endproperty
    a_rd: assert property (p_rd) else $error("shared lines driven during read");
    property p_wr; !wr_n |-> ad_oe && !latch_enable; endproperty
    a_wr: assert property (p_wr) else $error("write data not driven");
    property p_int; $rose(latch_enable) |-> cfg[3:2] != 2'h0; endproperty
    a_int: assert property (p_int) else $error("off-chip cycle in internal mode");
    property p_bank; $rose(latch_enable) && cfg[3:2] == 2'h2 |-> addr_hi_oe; endproperty
    a_bank: assert property (p_bank) else $error("high byte not driven in bank mode");
    property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");
endmodule
bind emmi_top emmi_top_chk emmi_top_chk_i (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_waitrequest, .ad_oe, .addr_hi_oe, .latch_enable, .rd_n, .wr_n);
`default_nettype wire

//--- dv/emmi_ext_mem.sv
`timescale 1ns/100ps
`default_nettype none
module emmi_ext_mem (
    // Port side
    input wire logic       clk,
    input wire logic       latch_enable,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       ad_oe,
    input wire logic [7:0] ad_out,
    input wire logic       addr_hi_oe,
    input wire logic [7:0] addr_hi_out,
    // High byte seen when the device leaves it undriven
    input wire logic [7:0] port_hi,
    output logic [7:0]     ad_in
);
    logic [7:0] lat;
    logic [7:0] last;
    logic [7:0] mem [0:65535];
    wire [15:0] a = {addr_hi_oe ? addr_hi_out : port_hi, lat};
    initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5a;
    always_latch if (latch_enable) lat <= ad_out;
    // Released lines show the inverse of their last level
    assign ad_in = ad_oe ? ad_out : !rd_n ? mem[a] : ~last;
    always @(posedge clk) begin
        last <= ad_in;
        if (!wr_n) mem[a] <= ad_in;
    end
endmodule
`default_nettype wire

//--- dv/emmi_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module emmi_top_bench;
    logic clk = 0, rst = 1, ce = 1, avs_read = 0, avs_write = 0, xreq = 0, xreq_write = 0, xreq_short = 0;
    logic [1:0] avs_address = 2'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [15:0] xreq_addr = 16'h0;
    logic [7:0] xreq_wdata = 8'h00, port_hi = 8'h00, xrdata, ad_in, ad_out, addr_hi_out, r;
    logic avs_waitrequest, xdone, ad_oe, addr_hi_oe, latch_enable, rd_n, wr_n;
    int n_mismatch = 0, checked = 0, n;
    always #10 clk = ~clk;
    emmi_top emmi_top_i (.clk, .rst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .xreq, .xreq_write, .xreq_short, .xreq_addr, .xreq_wdata, .xdone, .xrdata, .ad_in,
        .ad_out, .ad_oe, .addr_hi_out, .addr_hi_oe, .latch_enable, .rd_n, .wr_n);
    emmi_ext_mem emmi_ext_mem_i (.clk, .latch_enable, .rd_n, .wr_n, .ad_oe, .ad_out, .addr_hi_oe,
        .addr_hi_out, .port_hi, .ad_in);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_cnt(input int got, input int exp);
        checked++;
        if (got != exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t cycles=%h exp=%h", $time, got, exp);
        end
    endtask
    task av(input logic wr, input logic [1:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
    endtask
    // Latency counted from the cycle the request is raised to the xdone pulse
    task mv(input logic w, input logic s, input logic [15:0] a, input logic [7:0] d, input int lat);
        @(posedge clk);
        xreq <= 1;
        xreq_write <= w;
        xreq_short <= s;
        xreq_addr <= a;
        xreq_wdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (xdone !== 1'b1 && n < 300);
        r = xrdata;
        chk_cnt(n - 1, lat);
        xreq <= 0;
    endtask
    task finish_test;
        $display("mismatches=%0d checks=%0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        av(0, 2'h0, 0); chk(q, 32'h03);
        av(0, 2'h1, 0); chk(q, 32'h00);
        av(0, 2'h3, 0); chk(q, 32'h00);
        av(0, 2'h2, 0); chk(q, 32'h00);
        av(1, 2'h0, 32'hff); av(0, 2'h0, 0); chk(q, 32'h0f);
        av(1, 2'h0, 32'h03);
        av(1, 2'h3, 32'hf2); av(0, 2'h3, 0); chk(q, 32'h02);
        $display("test registers done");
        mv(1, 0, 16'h0805, 8'ha5, 3); chk(emmi_ext_mem_i.mem[16'h0805], 8'h5f);
        mv(0, 0, 16'h1005, 8'h00, 3); chk(r, 8'ha5);
        $display("test internal done");
        av(1, 2'h0, 32'h0f);
        mv(1, 0, 16'h0012, 8'h3c, 9); chk(emmi_ext_mem_i.mem[16'h0012], 8'h3c);
        mv(0, 0, 16'h0012, 8'h00, 9); chk(r, 8'h3c);
        $display("test external done");
        av(1, 2'h0, 32'h05);
        av(1, 2'h1, 32'h3a);
        port_hi <= 8'h61;
        mv(1, 1, 16'h0044, 8'h77, 11); chk(emmi_ext_mem_i.mem[16'h6144], 8'h77);
        mv(1, 0, 16'h0900, 8'h11, 11); chk(emmi_ext_mem_i.mem[16'h0900], 8'h11);
        mv(1, 0, 16'h0100, 8'h22, 3); chk(emmi_ext_mem_i.mem[16'h0100], 8'h5a);
        av(1, 2'h0, 32'h07);
        mv(0, 0, 16'h0900, 8'h00, 15); chk(r, 8'h11);
        $display("test split done");
        av(1, 2'h0, 32'h0b);
        av(1, 2'h1, 32'h5b);
        mv(1, 1, 16'h0007, 8'h99, 9); chk(emmi_ext_mem_i.mem[16'h5b07], 8'h99);
        mv(0, 0, 16'h0100, 8'h00, 3); chk(r, 8'h22);
        $display("test bank done");
        finish_test;
    end
endmodule
`default_nettype wire
